//--- include/display_keyboard_scanner_map.vh
`ifndef DISPLAY_KEYBOARD_SCANNER_MAP_VH
`define DISPLAY_KEYBOARD_SCANNER_MAP_VH

// clock rate in MHz
`define DKS_CLK_MHZ        25
// one scan slot, the blanking repeat period, in microseconds
`define DKS_SLOT_US        640
// blanking pulse width in microseconds
`define DKS_BLANK_US       150
// slot length in clock cycles (longest time, rounds down)
`define DKS_SLOT_CYC       (`DKS_SLOT_US * `DKS_CLK_MHZ)
// blanking length in clock cycles (least time, rounds up)
`define DKS_BLANK_CYC      (`DKS_BLANK_US * `DKS_CLK_MHZ)
// scan counter width: four divide-by-two stages
`define DKS_COUNT_BITS     4
// slot timer width
`define DKS_TIMER_BITS     15
// reset values; the strobe and column idle values are not loaded at reset
`define DKS_COUNT_RESET    4'h0
`define DKS_STROBES_IDLE   16'hFFFF
`define DKS_COLUMNS_IDLE   8'hFF
`define DKS_SEG_RESET      8'h00
// field positions of the key code: column above row
`define DKS_KEY_ROW_LSB    0
`define DKS_KEY_COL_LSB    3

`endif

//--- verilog/display_ram.v
`timescale 1ns/10ps

// small segment pattern store, one word per digit, registered read
module display_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter ABITS = 4
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             ce,
  input  wire             writeEnable,
  input  wire [ABITS-1:0] writeAddr,
  input  wire [WIDTH-1:0] writeData,
  input  wire [ABITS-1:0] readAddr,
  output reg  [WIDTH-1:0] readData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];  // pattern words, no reset needed

  // write port, frozen with the clock enable
  always @(posedge clk) begin
    if (ce && writeEnable) begin
      store[writeAddr] <= writeData;
    end
  end

  // read data comes out of a register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData <= {WIDTH{1'b0}};
    end else if (ce) begin
      readData <= store[readAddr];
    end
  end

endmodule // display_ram

//--- verilog/display_keyboard_scanner.v
`timescale 1ns/10ps
`include "display_keyboard_scanner_map.vh"

module display_keyboard_scanner #(
  parameter SLOT_CYC  = `DKS_SLOT_CYC,   // cycles in one scan slot
  parameter BLANK_CYC = `DKS_BLANK_CYC,  // cycles of blanking per slot
  parameter DIGITS    = 16,
  parameter COLUMNS   = 8,
  parameter ROWS      = 8
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         ce,
  input  wire         dispWrite,
  input  wire [3:0]   dispAddr,
  input  wire [7:0]   dispData,
  input  wire [7:0]   key_return_lines_n,
  output reg  [3:0]   scanCount,
  output reg  [15:0]  digitStrobe_n,
  output reg  [15:0]  digitCopy_n,
  output reg          blank_n,
  output reg  [7:0]   columnStrobe_n,
  output reg  [7:0]   segment,
  output reg          keyDown,
  output reg          keyStrobe,
  output reg  [5:0]   keyCode
);

  // integer copies first, then cut to the timer width on purpose
  localparam integer SLOT_LAST_I  = SLOT_CYC - 1;   // wrap value, full width
  localparam integer BLANK_LAST_I = BLANK_CYC - 1;  // last blanked cycle, full width
  localparam integer SAMPLE_AT_I  = BLANK_CYC;      // sample point, full width
  localparam [14:0]  SLOT_LAST    = SLOT_LAST_I[14:0];   // slot timer wrap value
  localparam [14:0]  BLANK_LAST   = BLANK_LAST_I[14:0];  // last blanked cycle
  localparam [14:0]  SAMPLE_AT    = SAMPLE_AT_I[14:0];   // returns sampled after blanking

  reg  [14:0] slotTimer;          // cycles within current slot
  reg  [7:0]  returnMeta;         // first synchroniser stage, read only below
  reg  [7:0]  returnSync;         // settled return lines
  reg  [3:0]  next_scanCount;
  reg  [15:0] next_digitStrobe_n;
  reg  [7:0]  next_columnStrobe_n;
  reg  [15:0] columnDecode;       // full decode before the column slice
  reg         next_blank_n;
  reg  [2:0]  rowFound;           // lowest row seen low
  reg         anyLow;             // some return low
  reg  [2:0]  sampledColumn;      // column active in this slot
  wire [7:0]  ramData;            // pattern of the digit being fetched
  integer     i;

  // one-hot active-low decode, shared by digits and columns
  function [15:0] decodeLow;
    input [3:0] index;
    begin
      decodeLow        = 16'hFFFF;
      decodeLow[index] = 1'b0;
    end
  endfunction

  // pattern store, read at the current digit; the registered read has
  // settled a few cycles into the slot, long before blanking ends
  display_ram #(
    .WIDTH (8),
    .DEPTH (DIGITS),
    .ABITS (4)
  ) u_ram (
    .clk         (clk),
    .reset_n     (reset_n),
    .ce          (ce),
    .writeEnable (dispWrite),
    .writeAddr   (dispAddr),
    .writeData   (dispData),
    .readAddr    (scanCount),
    .readData    (ramData)
  );

  // two-flop synchroniser on the keyswitch return pins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      returnMeta <= 8'hFF;
      returnSync <= 8'hFF;
    end else if (ce) begin
      returnMeta <= key_return_lines_n;
      returnSync <= returnMeta;
    end
  end

  // slot timer: the slot is the count period of the divider chain
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slotTimer <= 15'h0000;
    end else if (ce) begin
      if (slotTimer == SLOT_LAST) begin
        slotTimer <= 15'h0000;
      end else begin
        slotTimer <= slotTimer + 15'h0001;
      end
    end
  end

  // next count and strobes, decoded from the next count; blanking from the slot timer
  always @* begin
    next_scanCount = scanCount;
    if (slotTimer == SLOT_LAST) begin
      next_scanCount = scanCount + 4'h1;
    end
    // single low bit means exactly one digit at a time
    next_digitStrobe_n  = decodeLow(next_scanCount);
    // columns use the low three bits, so each repeats twice per frame
    columnDecode        = decodeLow({1'b0, next_scanCount[2:0]});
    next_columnStrobe_n = columnDecode[7:0];
    // blanking low at the head of every slot
    if (slotTimer == SLOT_LAST) begin
      next_blank_n = 1'b0;
    end else if (slotTimer == BLANK_LAST) begin
      next_blank_n = 1'b1;
    end else begin
      next_blank_n = blank_n;
    end
  end

  // scan outputs; every output comes from a flop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scanCount      <= `DKS_COUNT_RESET;
      digitStrobe_n  <= decodeLow(`DKS_COUNT_RESET);
      digitCopy_n    <= decodeLow(`DKS_COUNT_RESET);
      columnStrobe_n <= 8'hFE;
      blank_n        <= 1'b0;
    end else if (ce) begin
      scanCount      <= next_scanCount;
      digitStrobe_n  <= next_digitStrobe_n;
      digitCopy_n    <= next_digitStrobe_n;
      columnStrobe_n <= next_columnStrobe_n;
      blank_n        <= next_blank_n;
    end
  end

  // segment drive: pattern of the active digit, dark while blanked
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      segment <= `DKS_SEG_RESET;
    end else if (ce) begin
      if (slotTimer == SLOT_LAST) begin
        segment <= `DKS_SEG_RESET;                // blank while digit changes
      end else if (slotTimer == BLANK_LAST) begin
        segment <= ramData;
      end
    end
  end

  // lowest-numbered low return line wins on a multi-key press
  always @* begin
    rowFound      = 3'h0;
    anyLow        = 1'b0;
    sampledColumn = scanCount[2:0];
    for (i = ROWS - 1; i >= 0; i = i - 1) begin
      if (!returnSync[i]) begin
        rowFound = i[2:0];
        anyLow   = 1'b1;
      end
    end
  end

  // key detection: sample once per slot, past blanking and sync delay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      keyDown   <= 1'b0;
      keyStrobe <= 1'b0;
      keyCode   <= 6'h00;
    end else if (ce) begin
      keyStrobe <= 1'b0;
      if (slotTimer == SAMPLE_AT) begin
        if (anyLow) begin
          // return matches the active column
          keyCode[`DKS_KEY_ROW_LSB +: 3] <= rowFound;
          keyCode[`DKS_KEY_COL_LSB +: 3] <= sampledColumn;
          keyStrobe <= ~keyDown;                           // new press only
          keyDown   <= 1'b1;
        end else if (sampledColumn == keyCode[`DKS_KEY_COL_LSB +: 3]) begin
          // held key's column high again: released
          keyDown <= 1'b0;
        end
      end
    end
  end

endmodule // display_keyboard_scanner

//--- sim/display_keyboard_scanner_asserts.sv
`timescale 1ns/10ps
// pin-level watcher; figures assume SLOT_CYC 40, BLANK_CYC 8
// timing checks pause while ce is low, since every state freezes then
module display_keyboard_scanner_asserts #(
  parameter SLOT_CYC  = 40,
  parameter BLANK_CYC = 8
) (
  input wire        clk,
  input wire        reset_n,
  input wire        ce,
  input wire        dispWrite,
  input wire [3:0]  dispAddr,
  input wire [7:0]  dispData,
  input wire [7:0]  key_return_lines_n,
  input wire [3:0]  scanCount,
  input wire [15:0] digitStrobe_n,
  input wire [15:0] digitCopy_n,
  input wire        blank_n,
  input wire [7:0]  columnStrobe_n,
  input wire [7:0]  segment,
  input wire        keyDown,
  input wire        keyStrobe,
  input wire [5:0]  keyCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !ce);
  a_ce_freeze: assert property (disable iff (!reset_n) !ce |=> $stable(scanCount)
    && $stable(digitStrobe_n) && $stable(blank_n) && $stable(segment) && $stable(keyCode))
    else $error("state moved while disabled");
  a_one_digit: assert property ($onehot(~digitStrobe_n)) else $error("digit strobes");
  a_copy_same: assert property (digitCopy_n == digitStrobe_n) else $error("copy");
  a_digit_decode: assert property (digitStrobe_n == ~(16'h0001 << scanCount))
    else $error("digit decode");
  a_column_decode: assert property (columnStrobe_n == ~(8'h01 << scanCount[2:0]))
    else $error("column decode");
  a_count_step: assert property ($changed(scanCount) |-> scanCount == $past(scanCount) + 4'h1)
    else $error("count step");
  a_step_blanks: assert property ($changed(scanCount) |-> $fell(blank_n))
    else $error("step without blank");
  a_blank_width: assert property ($fell(blank_n) |-> !blank_n [*8] ##1 blank_n)
    else $error("blank width");
  a_blank_repeat: assert property ($fell(blank_n) |-> ##40 $fell(blank_n))
    else $error("blank period");
  a_lsb_square: assert property ($rose(scanCount[0]) |-> ##40 $fell(scanCount[0]) ##40
    $rose(scanCount[0])) else $error("lsb period");
  a_seg_dark: assert property (!blank_n |-> segment == 8'h00) else $error("segment lit");
  a_key_column: assert property (keyStrobe |-> keyDown && keyCode[5:3] == scanCount[2:0]
    ##1 !keyStrobe) else $error("key strobe");
endmodule // display_keyboard_scanner_asserts

bind display_keyboard_scanner display_keyboard_scanner_asserts #(.SLOT_CYC(SLOT_CYC),
  .BLANK_CYC(BLANK_CYC)) display_keyboard_scanner_asserts_i (
  .clk(clk), .reset_n(reset_n), .ce(ce), .dispWrite(dispWrite), .dispAddr(dispAddr),
  .dispData(dispData), .key_return_lines_n(key_return_lines_n), .scanCount(scanCount),
  .digitStrobe_n(digitStrobe_n), .digitCopy_n(digitCopy_n), .blank_n(blank_n),
  .columnStrobe_n(columnStrobe_n), .segment(segment), .keyDown(keyDown),
  .keyStrobe(keyStrobe), .keyCode(keyCode));

//--- sim/keyswitch_matrix.sv
`timescale 1ns/10ps
// one held key shorts its row to its column strobe
module keyswitch_matrix (
  input  wire [7:0] columnStrobe_n,
  input  wire       held,
  input  wire [2:0] heldCol,
  input  wire [2:0] heldRow,
  output wire [7:0] key_return_lines_n
);
  // rows are pulled up, so an open switch reads high
  assign key_return_lines_n = (held && !columnStrobe_n[heldCol]) ? ~(8'h01 << heldRow)
                              : 8'hFF;
endmodule // keyswitch_matrix

//--- sim/display_keyboard_scanner_tb.sv
`timescale 1ns/10ps
module display_keyboard_scanner_tb;
  reg         clk, reset_n, ce, dispWrite, held, segOn, lastBlank;
  reg  [3:0]  dispAddr;
  reg  [7:0]  dispData;
  reg  [2:0]  heldCol, heldRow;
  reg  [3:0]  holdCount;   // scan count seen as the enable drops
  reg  [7:0]  holdSeg;     // segments seen as the enable drops
  wire [7:0]  key_return_lines_n, columnStrobe_n, segment;
  wire [3:0]  scanCount;
  wire [15:0] digitStrobe_n, digitCopy_n;
  wire        blank_n, keyDown, keyStrobe;
  wire [5:0]  keyCode;
  reg  [7:0]  pat [0:15];  // expected segment pattern per digit
  reg  [5:0]  keyQ [$];    // expected key codes, oldest first
  integer     fails, compares, seed, i, n;

  // short slot so a frame is 640 cycles
  display_keyboard_scanner #(.SLOT_CYC(40), .BLANK_CYC(8)) display_keyboard_scanner_i (
    .clk(clk), .reset_n(reset_n), .ce(ce), .dispWrite(dispWrite), .dispAddr(dispAddr),
    .dispData(dispData), .key_return_lines_n(key_return_lines_n), .scanCount(scanCount),
    .digitStrobe_n(digitStrobe_n), .digitCopy_n(digitCopy_n), .blank_n(blank_n),
    .columnStrobe_n(columnStrobe_n), .segment(segment), .keyDown(keyDown),
    .keyStrobe(keyStrobe), .keyCode(keyCode));
  keyswitch_matrix keyswitch_matrix_i (
    .columnStrobe_n(columnStrobe_n), .held(held), .heldCol(heldCol), .heldRow(heldRow),
    .key_return_lines_n(key_return_lines_n));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // watcher: key strobes take the oldest note; segments checked as blanking ends
  always @(negedge clk) begin
    if (keyStrobe === 1'b1)
      chk(keyCode, keyQ.size() ? keyQ.pop_front() : 6'bxxxxxx);
    if (segOn && blank_n === 1'b1 && lastBlank === 1'b0)
      chk(segment, pat[scanCount]);
    lastBlank = blank_n;
  end

  // a hang counts as a failure
  initial begin
    #(40 * 10000);
    fails = fails + 1;
    conclude;
  end

  initial begin
    seed = 39129;
    fails = 0;
    compares = 0;
    {reset_n, dispWrite, held, segOn} = 4'h0;
    ce = 1'b1;
    dispAddr = 4'h0;
    dispData = 8'h00;
    {heldCol, heldRow} = 6'h00;
    repeat (4) @(negedge clk);
    chk(digitStrobe_n, 16'hFFFE);
    chk(columnStrobe_n, 8'hFE);
    chk(digitCopy_n, 16'hFFFE);
    chk(blank_n, 1'b0);
    chk(segment, 8'h00);
    chk(scanCount, 4'h0);
    chk(keyDown, 1'b0);
    reset_n = 1'b1;
    // back-to-back pattern writes, strobe held up
    for (i = 0; i < 16; i = i + 1) begin
      n = $random(seed);
      pat[i] = n[7:0];
      dispAddr = i[3:0];
      dispData = n[7:0];
      dispWrite = 1'b1;
      @(negedge clk);
    end
    dispWrite = 1'b0;
    repeat (80) @(negedge clk);
    segOn = 1'b1;
    // random keys: press, wait for the strobe, release
    for (i = 0; i < 6; i = i + 1) begin
      n = $random(seed);
      heldCol = n[2:0];
      heldRow = n[5:3];
      held = 1'b1;
      keyQ.push_back({n[2:0], n[5:3]});
      n = 0;
      while (n < 400 && keyStrobe !== 1'b1) begin
        @(negedge clk);
        n = n + 1;
      end
      @(negedge clk);
      chk(keyDown, 1'b1);
      held = 1'b0;
      repeat (400) @(negedge clk);
      chk(keyDown, 1'b0);
    end
    chk(keyQ.size(), 16'h0000);
    // enable low: the whole scan stands still
    holdCount = scanCount;
    holdSeg = segment;
    ce = 1'b0;
    repeat (60) @(negedge clk);
    chk(scanCount, holdCount);
    chk(segment, holdSeg);
    ce = 1'b1;
    // reset in mid-run: the scan restarts from digit zero
    repeat (17) @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(scanCount, 4'h0);
    chk(digitStrobe_n, 16'hFFFE);
    reset_n = 1'b1;
    // two slots of 40 cycles later the third digit is up
    repeat (100) @(negedge clk);
    chk(scanCount, 4'h2);
    chk(digitStrobe_n, 16'hFFFB);
    chk(columnStrobe_n, 8'hFB);
    conclude;
  end
endmodule // display_keyboard_scanner_tb
